//--- dar_receiver.sv
// device end: phase-aligning receiver channels with per-channel synchronizer fifo
//
// Function
// - eight equally spaced clock phases per bit
// - capture on phase nearest data eye
// - each channel picks its own phase
// - phase step is one eighth bit
// - forwarded clock times W gives bit rate
// - forwarded clock sampled through the pin synchronizers like data, never used as a clock
// - measure and correct phase at the end of every bit that holds a data edge
// - alignment automatic, continuous, no user choice
// - retimed data and phase feed deserializer
// - run-of-ten training repeated 256 times
// - alternative lock pattern 00001111 or 10010000
// - general lock pattern 10101010 or 01010101
// - each channel has own global-clock synchronizer
// - synchronizer fifo four deep, J wide
// - written on parallel clock, read global
// - parallel and global clocks equal frequency
// - fifo free running, no flags or enables
// - deserialization factor limited to 8 or 10
`timescale 1ns/100ps
`default_nettype none

module dar_receiver
  import dar_pkg::*;
#(
  parameter  int NCH = 2,
  parameter  int W   = 10,
  parameter  int J   = 10,
  localparam int JW  = (J == 8) ? 8 : 10,
  localparam int FP  = W * PHASES,
  localparam int FW  = $clog2(FP + 1),
  localparam int GP  = JW * PHASES,
  localparam int GW  = $clog2(GP + 1)
)
(
  input  wire logic                     clock,
  input  wire logic                     rstn,
  dar_link.rx                           link,
  output var  logic [NCH-1:0][JW-1:0]   rx_word,
  output var  logic                     rx_word_valid,
  output var  logic [NCH-1:0][PH_W-1:0] rx_phase,
  output var  logic [NCH-1:0]           rx_locked
);

  // ----------------------------------------------------------------
  // pin synchronizers
  // ----------------------------------------------------------------
  logic                         fclk_s1;
  logic                         fclk_s2;
  logic                         fclk_q;
  logic [NCH-1:0]               dat_s1;
  logic [NCH-1:0]               dat_s2;
  logic [NCH-1:0]               dat_q;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      // forwarded clock idles high in reset; a low start would fake a rise
      fclk_s1 <= 1'b1;
      fclk_s2 <= 1'b1;
      fclk_q  <= 1'b1;
      dat_s1  <= '0;
      dat_s2  <= '0;
      dat_q   <= '0;
    end
    else
    begin
      fclk_s1 <= link.fwd_clk;
      fclk_s2 <= fclk_s1;
      fclk_q  <= fclk_s2;
      dat_s1  <= link.ser_data;
      dat_s2  <= dat_s1;
      dat_q   <= dat_s2;
    end
  end

  // ----------------------------------------------------------------
  // phase generator locked to the forwarded clock
  // ----------------------------------------------------------------
  logic [FW-1:0]                cyc;
  logic [FW-1:0]                next_cyc;
  logic [PH_W-1:0]              phase;

  // each system cycle stands for one of the eight phases of a bit
  assign phase = cyc[PH_W-1:0];

  always_comb
  begin
    // W bits of eight phases fill one forwarded period
    if (fclk_s2 && !fclk_q)
      next_cyc = '0;
    else if (cyc == FW'(FP - 1))
      next_cyc = '0;
    else
      next_cyc = cyc + FW'(1);
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      cyc <= '0;
    else
      cyc <= next_cyc;
  end

  // ----------------------------------------------------------------
  // per-channel phase selector, deserializer and fifo write side
  // ----------------------------------------------------------------
  logic [NCH-1:0]                         seen;
  logic [NCH-1:0]                         next_seen;
  logic [NCH-1:0][PH_W-1:0]               tph;
  logic [NCH-1:0][PH_W-1:0]               next_tph;
  logic [NCH-1:0][PH_W-1:0]               sel;
  logic [NCH-1:0][PH_W-1:0]               next_sel;
  logic [NCH-1:0]                         locked;
  logic [NCH-1:0]                         next_locked;
  logic [NCH-1:0][JW-1:0]                 sh;
  logic [NCH-1:0][JW-1:0]                 next_sh;
  logic [NCH-1:0][3:0]                    bcnt;
  logic [NCH-1:0][3:0]                    next_bcnt;
  logic [NCH-1:0][PTR_W-1:0]              wp;
  logic [NCH-1:0][PTR_W-1:0]              next_wp;
  logic [NCH-1:0][FIFO_DEPTH-1:0][JW-1:0] mem;
  logic [NCH-1:0][FIFO_DEPTH-1:0][JW-1:0] next_mem;
  logic                                   run;
  logic                                   next_run;

  always_comb
  begin
    next_seen   = seen;
    next_tph    = tph;
    next_sel    = sel;
    next_locked = locked;
    next_sh     = sh;
    next_bcnt   = bcnt;
    next_wp     = wp;
    next_mem    = mem;
    next_run    = run;
    for (int c = 0; c < NCH; c++)
    begin
      // bit boundary: move the strobe half a bit from the last edge seen
      if (phase == PHASE_LAST && seen[c])
      begin
        next_sel[c]    = tph[c] + SEL_OFFSET;
        next_locked[c] = 1'b1;
        next_seen[c]   = 1'b0;
      end
      // an edge in the boundary cycle is kept for the next bit
      if (dat_s2[c] != dat_q[c])
      begin
        next_seen[c] = 1'b1;
        next_tph[c]  = phase;
      end
      // a phase step across the strobe may drop or repeat one bit
      if (locked[c] && phase == sel[c])
      begin
        next_sh[c] = {sh[c][JW-2:0], dat_s2[c]};
        if (bcnt[c] == 4'(JW - 1))
        begin
          next_bcnt[c]         = 4'h0;
          next_mem[c][wp[c]]   = next_sh[c];
          next_wp[c]           = wp[c] + 2'h1;
          if (c == 0)
            next_run = 1'b1;
        end
        else
          next_bcnt[c] = bcnt[c] + 4'h1;
      end
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      seen   <= '0;
      tph    <= '0;
      sel    <= '0;
      locked <= '0;
      sh     <= '0;
      bcnt   <= '0;
      wp     <= {NCH{WP_RESET}};
      mem    <= '0;
      run    <= 1'b0;
    end
    else
    begin
      seen   <= next_seen;
      tph    <= next_tph;
      sel    <= next_sel;
      locked <= next_locked;
      sh     <= next_sh;
      bcnt   <= next_bcnt;
      wp     <= next_wp;
      mem    <= next_mem;
      run    <= next_run;
    end
  end

  // ----------------------------------------------------------------
  // shared global clock enable and fifo read side
  // ----------------------------------------------------------------
  logic [GW-1:0]                gcnt;
  logic [GW-1:0]                next_gcnt;
  logic [PTR_W-1:0]             rp;
  logic [PTR_W-1:0]             next_rp;
  logic [NCH-1:0][JW-1:0]       next_word;
  logic                         next_valid;

  always_comb
  begin
    next_gcnt  = gcnt;
    next_rp    = rp;
    next_word  = rx_word;
    next_valid = 1'b0;
    // same J-bit period as every parallel clock, only the phase differs
    if (run)
    begin
      if (gcnt == GW'(GP - 1))
      begin
        next_gcnt  = '0;
        next_rp    = rp + 2'h1;
        next_valid = 1'b1;
        for (int c = 0; c < NCH; c++)
          next_word[c] = mem[c][rp];
      end
      else
        next_gcnt = gcnt + GW'(1);
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      gcnt          <= '0;
      rp            <= RP_RESET;
      rx_word       <= '0;
      rx_word_valid <= 1'b0;
      rx_phase      <= '0;
      rx_locked     <= '0;
    end
    else
    begin
      gcnt          <= next_gcnt;
      rp            <= next_rp;
      rx_word       <= next_word;
      rx_word_valid <= next_valid;
      rx_phase      <= sel;
      rx_locked     <= locked;
    end
  end

endmodule

`default_nettype wire

//--- dar_pkg.sv
// shared constants, types and helpers for the phase-aligned link ends
`default_nettype none

package dar_pkg;

  // ----------------------------------------------------------------
  // phases and timing
  // ----------------------------------------------------------------
  localparam int           PHASES        = 8;
  localparam int           PH_W          = 3;
  localparam logic [2:0]   PHASE_FIRST   = 3'h0;
  localparam logic [2:0]   PHASE_LAST    = 3'h7;
  localparam logic [2:0]   SEL_OFFSET    = 3'h4;
  localparam int           BIT_PERIOD_PS = 1000;
  localparam int           PHASE_STEP_PS = BIT_PERIOD_PS / PHASES;

  // ----------------------------------------------------------------
  // synchronizer fifo
  // ----------------------------------------------------------------
  localparam int           FIFO_DEPTH    = 4;
  localparam int           PTR_W         = 2;
  localparam logic [1:0]   WP_RESET      = 2'h2;
  localparam logic [1:0]   RP_RESET      = 2'h0;

  // ----------------------------------------------------------------
  // training
  // ----------------------------------------------------------------
  localparam int           TRAIN_REPS    = 256;
  localparam int           REP_W         = 9;
  localparam logic [4:0]   RUN_LEN       = 5'h0a;
  localparam logic [4:0]   RUN_PERIOD    = 5'h14;
  localparam logic [4:0]   BYTE_PERIOD   = 5'h08;
  localparam logic [4:0]   QUAD_LEN      = 5'h04;
  localparam logic [4:0]   SPARSE_B      = 5'h03;

  typedef enum logic [2:0]
  {
    DAR_PAT_RUN10  = 3'h0,
    DAR_PAT_QUAD   = 3'h1,
    DAR_PAT_SPARSE = 3'h3,
    DAR_PAT_ALT10  = 3'h2,
    DAR_PAT_ALT01  = 3'h6
  } dar_pattern_e;

  typedef enum logic [1:0]
  {
    DAR_TX_TRAIN   = 2'b00,
    DAR_TX_PAYLOAD = 2'b01
  } dar_tx_state_e;

  function automatic logic [4:0] dar_pat_len(input dar_pattern_e m);
    dar_pat_len = (m == DAR_PAT_RUN10) ? RUN_PERIOD : BYTE_PERIOD;
  endfunction

  function automatic logic dar_pat_bit(input dar_pattern_e m, input logic [4:0] p);
    case (m)
      DAR_PAT_RUN10:  dar_pat_bit = (p >= RUN_LEN);
      DAR_PAT_QUAD:   dar_pat_bit = (p >= QUAD_LEN);
      DAR_PAT_SPARSE: dar_pat_bit = (p == 5'h00) || (p == SPARSE_B);
      DAR_PAT_ALT10:  dar_pat_bit = ~p[0];
      DAR_PAT_ALT01:  dar_pat_bit = p[0];
      default:        dar_pat_bit = ~p[0];
    endcase
  endfunction

endpackage

`default_nettype wire

//--- dar_link.sv
// link between the forwarding transmitter and the phase-aligning receiver
`timescale 1ns/100ps
`default_nettype none

interface dar_link #(parameter int NCH = 2) ();
  logic           fwd_clk;
  logic [NCH-1:0] ser_data;

  modport tx
  (
    output fwd_clk,
    output ser_data
  );

  modport rx
  (
    input  fwd_clk,
    input  ser_data
  );
endinterface

`default_nettype wire

//--- dar_transmitter.sv
// far end: serializing transmitter with forwarded clock and lock patterns
`timescale 1ns/100ps
`default_nettype none

module dar_transmitter
  import dar_pkg::*;
#(
  parameter  int NCH = 2,
  parameter  int W   = 10,
  parameter  int J   = 10,
  localparam int JW  = (J == 8) ? 8 : 10,
  localparam int FP  = W * PHASES,
  localparam int FW  = $clog2(FP + 1)
)
(
  input  wire logic                   clock,
  input  wire logic                   rstn,
  dar_link.tx                         link,
  input  wire dar_pattern_e           mode,
  input  wire logic [NCH-1:0][JW-1:0] tx_word,
  output var  logic                   tx_take,
  output var  logic                   tx_training
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  dar_tx_state_e                state;
  dar_tx_state_e                next_state;
  logic [PH_W-1:0]              ph;
  logic [PH_W-1:0]              next_ph;
  logic [FW-1:0]                fcnt;
  logic [FW-1:0]                next_fcnt;
  logic                         fwd;
  logic                         next_fwd;
  logic [4:0]                   pcnt;
  logic [4:0]                   next_pcnt;
  logic [REP_W-1:0]             reps;
  logic [REP_W-1:0]             next_reps;
  logic                         done;
  logic                         next_done;
  logic [3:0]                   bcnt;
  logic [3:0]                   next_bcnt;
  logic [NCH-1:0][JW-1:0]       sh;
  logic [NCH-1:0][JW-1:0]       next_sh;
  logic [NCH-1:0]               ser;
  logic [NCH-1:0]               next_ser;
  logic                         next_take;

  assign link.fwd_clk  = fwd;
  assign link.ser_data = ser;

  // ----------------------------------------------------------------
  // bit timing, forwarded clock and pattern
  // ----------------------------------------------------------------
  always_comb
  begin
    next_state = state;
    next_ph    = ph + 3'h1;
    next_fcnt  = (fcnt == FW'(FP - 1)) ? '0 : fcnt + FW'(1);
    next_fwd   = (next_fcnt < FW'(FP / 2));
    next_pcnt  = pcnt;
    next_reps  = reps;
    next_done  = done;
    next_bcnt  = bcnt;
    next_sh    = sh;
    next_ser   = ser;
    next_take  = 1'b0;
    if (ph == PHASE_LAST)
    begin
      next_bcnt = (bcnt == 4'(JW - 1)) ? 4'h0 : bcnt + 4'h1;
      if (pcnt >= dar_pat_len(mode) - 5'h01)
      begin
        next_pcnt = 5'h00;
        next_reps = reps + REP_W'(1);
        if (reps == REP_W'(TRAIN_REPS - 1))
          next_done = 1'b1;
      end
      else
        next_pcnt = pcnt + 5'h01;
      case (state)
        DAR_TX_TRAIN:
        begin
          for (int c = 0; c < NCH; c++)
            next_ser[c] = dar_pat_bit(mode, next_pcnt);
          // switch only on a word edge so payload words stay framed
          if (done && bcnt == 4'(JW - 1))
          begin
            next_state = DAR_TX_PAYLOAD;
            next_sh    = tx_word;
            next_take  = 1'b1;
            for (int c = 0; c < NCH; c++)
              next_ser[c] = tx_word[c][JW-1];
          end
        end
        DAR_TX_PAYLOAD:
        begin
          if (bcnt == 4'(JW - 1))
          begin
            next_sh   = tx_word;
            next_take = 1'b1;
          end
          else
          begin
            for (int c = 0; c < NCH; c++)
              next_sh[c] = {sh[c][JW-2:0], 1'b0};
          end
          for (int c = 0; c < NCH; c++)
            next_ser[c] = next_sh[c][JW-1];
        end
        default:
          next_state = DAR_TX_TRAIN;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      state       <= DAR_TX_TRAIN;
      ph          <= '0;
      fcnt        <= '0;
      fwd         <= 1'b1;
      pcnt        <= '0;
      reps        <= '0;
      done        <= 1'b0;
      bcnt        <= '0;
      sh          <= '0;
      ser         <= '0;
      tx_take     <= 1'b0;
      tx_training <= 1'b1;
    end
    else
    begin
      state       <= next_state;
      ph          <= next_ph;
      fcnt        <= next_fcnt;
      fwd         <= next_fwd;
      pcnt        <= next_pcnt;
      reps        <= next_reps;
      done        <= next_done;
      bcnt        <= next_bcnt;
      sh          <= next_sh;
      ser         <= next_ser;
      tx_take     <= next_take;
      tx_training <= (next_state == DAR_TX_TRAIN);
    end
  end

endmodule

`default_nettype wire

//--- dar_assertions.sv
// concurrent checks on the link and the user ports of both ends
`timescale 1ns/100ps
`default_nettype none

module dar_assertions
  import dar_pkg::*;
#(
  parameter  int NCH = 2,
  parameter  int W   = 10,
  parameter  int J   = 10,
  localparam int JW  = (J == 8) ? 8 : 10
)
(
  input wire logic                   clock,
  input wire logic                   rstn,
  input wire logic                   fwd_clk,
  input wire logic [NCH-1:0]         ser_data,
  input wire logic                   tx_take,
  input wire logic                   tx_training,
  input wire logic [NCH-1:0][JW-1:0] rx_word,
  input wire logic                   rx_word_valid,
  input wire logic [NCH-1:0]         rx_locked
);
  localparam int FH = W * PHASES / 2;
  localparam int VG = JW * PHASES;
  logic           fprev;
  logic           fseen;
  logic           sseen;
  logic           vseen;
  logic [NCH-1:0] sprev;
  logic [15:0]    fcnt;
  logic [15:0]    vcnt;
  logic [2:0]     bcnt;
  wire logic      fchg = fwd_clk != fprev;
  wire logic      schg = ser_data != sprev;

  // ----
  // spacing counters, first interval skipped since reset start is loose
  // ----
  always_ff @(posedge clock or negedge rstn)
    if (!rstn)
    begin
      fprev <= 1'b1;
      sprev <= '0;
      fseen <= 1'b0;
      sseen <= 1'b0;
      vseen <= 1'b0;
      fcnt  <= 16'h0;
      vcnt  <= 16'h0;
      bcnt  <= 3'h0;
    end
    else
    begin
      fprev <= fwd_clk;
      sprev <= ser_data;
      fseen <= fseen | fchg;
      sseen <= sseen | schg;
      vseen <= vseen | rx_word_valid;
      fcnt  <= fchg ? 16'h0 : fcnt + 16'h1;
      vcnt  <= rx_word_valid ? 16'h0 : vcnt + 16'h1;
      bcnt  <= schg ? 3'h0 : bcnt + 3'h1;
    end

  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  a_fwd_half_period: assert property (fchg && fseen |-> fcnt == FH - 1)
    else $error("forwarded clock half period wrong");
  a_bit_eighths: assert property (schg && sseen |-> bcnt == 3'h7)
    else $error("serial bit not eight steps long");
  a_word_spacing: assert property (rx_word_valid && vseen |-> vcnt == VG - 1)
    else $error("global read spacing wrong");
  a_word_holds: assert property (!rx_word_valid |-> $stable(rx_word))
    else $error("rx word changed without read");
  a_take_single: assert property (tx_take |=> !tx_take [*8])
    else $error("word load too close");
  a_take_ends_training: assert property ($fell(tx_training) |-> tx_take)
    else $error("training end without word load");
  a_no_take_training: assert property (tx_training |-> !tx_take)
    else $error("word load during training");
  a_lock_sticks: assert property (($past(rx_locked) & ~rx_locked) == '0)
    else $error("lock dropped");

  c_payload: cover property (tx_take);
  c_word_read: cover property (rx_word_valid && rx_locked[0]);
  c_train_end: cover property ($fell(tx_training));
endmodule

`default_nettype wire

//--- dynamic_phase_align_receiver_tb.sv
// bench: transmitter and receiver joined by the link
`timescale 1ns/100ps
`default_nettype none

module dynamic_phase_align_receiver_tb
  import dar_pkg::*;
;
  localparam int NCH = 2;
  localparam int J   = 10;
  logic                     clock = 1'b0;
  logic                     rstn  = 1'b0;
  dar_pattern_e             mode  = DAR_PAT_ALT10;
  logic [NCH-1:0][J-1:0]    tx_word = {10'h2c7, 10'h135};
  logic                     tx_take;
  logic                     tx_training;
  logic                     rx_word_valid;
  logic [NCH-1:0][J-1:0]    rx_word;
  logic [NCH-1:0][PH_W-1:0] rx_phase;
  logic [NCH-1:0]           rx_locked;
  int                       errors = 0;
  int                       tests_run = 0;
  logic [19:0]              pat [5] = '{20'h003ff, 20'h0000f, 20'h00090, 20'h000aa, 20'h00055};
  int                       plen [5] = '{20, 8, 8, 8, 8};
  dar_pattern_e             pmode [5] = '{DAR_PAT_RUN10, DAR_PAT_QUAD, DAR_PAT_SPARSE, DAR_PAT_ALT10, DAR_PAT_ALT01};

  always #20 clock = ~clock;

  dar_link #(.NCH(NCH)) link ();
  dar_transmitter #(.NCH(NCH), .J(J)) u_dar_transmitter (.clock(clock), .rstn(rstn), .link(link.tx),
    .mode(mode), .tx_word(tx_word), .tx_take(tx_take), .tx_training(tx_training));
  dar_receiver #(.NCH(NCH), .J(J)) u_dar_receiver (.clock(clock), .rstn(rstn), .link(link.rx),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_phase(rx_phase), .rx_locked(rx_locked));
  dar_assertions #(.NCH(NCH), .W(10), .J(J)) u_dar_assertions (.clock(clock), .rstn(rstn),
    .fwd_clk(link.fwd_clk), .ser_data(link.ser_data), .tx_take(tx_take), .tx_training(tx_training),
    .rx_word(rx_word), .rx_word_valid(rx_word_valid), .rx_locked(rx_locked));

  // ----
  // helpers
  // ----
  task automatic tick();
    @(posedge clock);
    #1;
  endtask

  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    tests_run++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic final_report();
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  task automatic timeout(input string what);
    errors++;
    $display("ERROR %s expected event seen timeout", what);
    final_report();
  endtask

  task automatic do_reset();
    rstn = 1'b0;
    repeat (5) tick();
    rstn = 1'b1;
  endtask

  task automatic wait_valid();
    int i;
    for (i = 0; i < 400; i++)
    begin
      tick();
      if (rx_word_valid === 1'b1)
        break;
    end
    if (i == 400)
      timeout("rx_word_valid");
  endtask

  // no byte realignment, so any rotation of the sent word is right
  function automatic logic is_rot(input logic [J-1:0] a, input logic [J-1:0] b);
    logic [2*J-1:0] d;
    d = {a, a};
    is_rot = 1'b0;
    for (int r = 0; r < J; r++)
      if (d[r +: J] === b)
        is_rot = 1'b1;
  endfunction

  // ----
  // sequence
  // ----
  initial
  begin
    logic                     bits [40];
    logic                     found;
    logic                     ok;
    logic [NCH-1:0][PH_W-1:0] ph;
    int                       n;
    int                       len;
    time                      t0;
    // wire pattern only; full training per mode would be too long
    for (int m = 0; m < 5; m++)
    begin
      mode = pmode[m];
      do_reset();
      for (n = 0; n < 400 && link.ser_data[0] === 1'b0; n++)
        tick();
      if (n == 400)
        timeout("ser_data");
      repeat (4) tick();
      len = plen[m];
      for (int k = 0; k < 2 * len; k++)
      begin
        bits[k] = link.ser_data[0];
        repeat (8) tick();
      end
      found = 1'b0;
      for (int r = 0; r < len; r++)
      begin
        ok = 1'b1;
        for (int k = 0; k < 2 * len; k++)
          if (bits[k] !== pat[m][len - 1 - (k + r) % len])
            ok = 1'b0;
        found |= ok;
      end
      check("training pattern", 32'h1, {31'h0, found});
    end
    $display("test patterns done");
    mode = DAR_PAT_ALT10;
    do_reset();
    t0 = $time;
    wait_valid();
    check("first word", 32'h0, rx_word);
    wait_valid();
    check("second word", 32'h0, rx_word);
    for (n = 0; n < 20000 && tx_take !== 1'b1; n++)
      tick();
    if (n == 20000)
      timeout("tx_take");
    n = int'(($time - t0) / 40);
    check("training cycles", 32'h1, (n >= TRAIN_REPS * 64 - 8) && (n <= TRAIN_REPS * 64 + 16));
    $display("test training done");
    repeat (4) tick();
    for (int b = J - 1; b >= 0; b--)
    begin
      check("wire bit 0", tx_word[0][b], link.ser_data[0]);
      check("wire bit 1", tx_word[1][b], link.ser_data[1]);
      repeat (8) tick();
    end
    $display("test wire order done");
    repeat (5) wait_valid();
    ph = rx_phase;
    repeat (3)
    begin
      wait_valid();
      check("rx word 0", 32'h1, is_rot(tx_word[0], rx_word[0]));
      check("rx word 1", 32'h1, is_rot(tx_word[1], rx_word[1]));
      check("locked", 32'h3, rx_locked);
      check("phase held", ph, rx_phase);
      check("phase pair", rx_phase[0], rx_phase[1]);
    end
    $display("test receiver done");
    final_report();
  end
endmodule

`default_nettype wire
